// ===== shared/fsc_pkg.sv
// Constants, carrier types and helpers for the security-area command block
`default_nettype none
package fsc_pkg;
	// ==========================================================
	// Opcodes
	localparam logic [7:0] OPC_SFDP_RD = 8'h5A;
	localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
	localparam logic [7:0] OPC_SEC_PROG = 8'h42;
	localparam logic [7:0] OPC_SEC_RD = 8'h48;
	localparam logic [7:0] OPC_ID_DUAL = 8'h92;
	localparam logic [7:0] OPC_ID_QUAD = 8'h94;
	localparam logic [7:0] OPC_UID_RD = 8'h4B;

	// ==========================================================
	// Frame points, in rising link clock edges since select fell
	localparam logic [6:0] CNT_OPC_END = 7'h08;
	localparam logic [6:0] CNT_ADDR_END = 7'h20;
	localparam logic [6:0] CNT_DATA_START = 7'h28;
	localparam logic [6:0] CNT_DUAL_START = 7'h18;
	localparam logic [6:0] CNT_QUAD_START = 7'h14;
	localparam logic [6:0] CNT_MAX = 7'h7F;

	// ==========================================================
	// Security areas
	localparam logic [7:0] AREA1_CODE = 8'h10;
	localparam logic [7:0] AREA2_CODE = 8'h20;
	localparam logic [7:0] AREA3_CODE = 8'h30;
	localparam logic [1:0] AREA_NONE = 2'h3;
	localparam int AREA_COUNT = 3;
	localparam int AREA_BYTES = 256;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ==========================================================
	// Register map and reset values
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int CTRL_WEL_SET_BIT = 0;
	localparam int CTRL_WEL_CLR_BIT = 1;
	localparam int LOCK_LSB = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WEL_BIT = 1;
	localparam int STAT_ARM_BIT = 5;
	localparam logic WEL_RST = 1'b0;
	localparam logic [2:0] LOCK_RST = 3'h0;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int ERASE_TIME_US = 100;
	localparam int ERASE_CYCLES_DEF = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;

	// ==========================================================
	// Link-to-core event carrier
	typedef enum logic [1:0] {
		EV_READ = 2'h0,
		EV_PROG = 2'h1,
		EV_ARM = 2'h2,
		EV_DISARM = 2'h3
	} fsc_ev_kind_t;

	typedef struct packed {
		logic tgl;
		fsc_ev_kind_t kind;
		logic [23:0] addr;
		logic [7:0] data;
	} fsc_event_t;

	// Area index from a command address, AREA_NONE when undefined
	function automatic logic [1:0] fsc_area_idx(input logic [23:0] a);
		if (a[23:16] != 8'h00) begin
			return AREA_NONE;
		end
		case (a[15:8])
			AREA1_CODE: return 2'h0;
			AREA2_CODE: return 2'h1;
			AREA3_CODE: return 2'h2;
			default: return AREA_NONE;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== rtl/fsc_sync.sv
// Two-flop level synchroniser
`default_nettype none
`timescale 1ns/100ps
module fsc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Destination clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Level in and out
	input wire logic i_d,
	output logic o_q
);
	logic [1:0] sync_ff;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync_ff <= {2{RST_VAL}};
		end else begin
			sync_ff <= {sync_ff[0], i_d};
		end
	end

	assign o_q = sync_ff[1];
endmodule
`default_nettype wire

// ===== rtl/fsc_secmem.sv
// Storage for the three one-time-lockable security areas
`default_nettype none
`timescale 1ns/100ps
module fsc_secmem import fsc_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Write side
	input wire logic i_we,
	input wire logic i_erase,
	input wire logic [9:0] i_waddr,
	input wire logic [7:0] i_wdata,
	// Read side
	input wire logic [9:0] i_raddr,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:AREA_COUNT*AREA_BYTES-1];

	// Programming only clears bits, so unerased cells cannot be raised
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_erase ? ERASED_BYTE : (mem[i_waddr] & i_wdata);
		end
		o_rdata <= mem[i_raddr];
	end

	chk_prog_and_only: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_we && !i_erase) |=> mem[$past(i_waddr)] == ($past(mem[i_waddr]) & $past(i_wdata)))
		else $error("Program did not AND data into cell");
	chk_erase_fill: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_we && i_erase) |=> mem[$past(i_waddr)] == ERASED_BYTE)
		else $error("Erased cell not FF");
endmodule
`default_nettype wire

// ===== rtl/fsc_top.sv
// Security area, parameter area and identification command handler
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`default_nettype none
`timescale 1ns/100ps
// Functional notes
// - Parameter read 5Ah: data from clock 40
// - Parameter read uses low address byte as offset
// - Three independent erasable, programmable 256-byte areas
// - Area erase needs write latch set
// - Area code in address middle byte
// - Erase runs only if select rises after 32
// - Erase self-timed, busy shown throughout
// - Erase completion clears write latch
// - Locked area ignores erase and program
// - Program needs latch, ANDs bytes into cells
// - Area read: 48h, address, dummy, MSB first
// - Read offset increments, wraps within area
// - Undefined addresses give undefined data
// - Dual identification read, two bits per edge
// - Quad identification read, four bits per edge
// - Unique number read after four dummy bytes
module fsc_top import fsc_pkg::*; #(
	parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
	parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h3C, // Arbitrary value
	parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
	// Core clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// Link pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe
);
	localparam int ECW = $clog2(ERASE_CYCLES) + 1;

	typedef struct packed {
		logic [6:0] cnt;
		logic [31:0] shin;
		logic [7:0] opc;
		logic [23:0] addr;
		logic dphase;
		logic [2:0] bidx;
		logic [7:0] koff;
		logic [7:0] oshr;
	} fsc_lnk_t;

	typedef struct packed {
		logic [3:0] io;
		logic [3:0] oe;
	} fsc_drv_t;

	typedef enum logic [1:0] {
		CORE_IDLE = 2'b01,
		CORE_ERASE = 2'b10
	} fsc_core_state_t;

	typedef struct packed {
		fsc_core_state_t state;
		logic req_seen;
		logic cs_q;
		logic armed;
		logic prog_seen;
		logic [1:0] area;
		logic [ECW-1:0] ecnt;
		logic write_latch_flag;
		logic [2:0] lock;
		logic [9:0] raddr;
		logic rd_bad;
		logic [1:0] rd_pend;
		logic ack;
		logic [7:0] rdata;
		logic [31:0] reg_rdata;
	} fsc_core_t;

	fsc_lnk_t lnk_ff, nxt_lnk;
	fsc_event_t evt_ff, nxt_evt;
	fsc_drv_t drv_ff, nxt_drv;
	fsc_core_t core_ff, nxt_core;
	logic lnk_rst_n;
	logic ack_sync;
	logic req_sync;
	logic cs_sync;
	logic mem_we;
	logic mem_erase;
	logic [9:0] mem_waddr;
	logic [7:0] mem_rdata;

	// ==========================================================
	// Helpers
	function automatic logic [2:0] bus_width(input logic [7:0] opc, input logic [6:0] cnt);
		if (cnt < CNT_OPC_END) begin
			return 3'h1;
		end else if (opc == OPC_ID_DUAL) begin
			return 3'h2;
		end else if (opc == OPC_ID_QUAD) begin
			return 3'h4;
		end
		return 3'h1;
	endfunction

	function automatic logic [6:0] data_start(input logic [7:0] opc);
		case (opc)
			OPC_SFDP_RD, OPC_SEC_RD, OPC_UID_RD: return CNT_DATA_START;
			OPC_ID_DUAL: return CNT_DUAL_START;
			OPC_ID_QUAD: return CNT_QUAD_START;
			default: return 7'h00;
		endcase
	endfunction

	function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
		case (a)
			8'h00: return 8'h53;
			8'h01: return 8'h46;
			8'h02: return 8'h44;
			8'h03: return 8'h50;
			default: return 8'hFF;
		endcase
	endfunction

	// ==========================================================
	// Link domain, rising edges
	// Select high holds the whole frame state in reset
	assign lnk_rst_n = i_resetn & ~i_cs_n;

	fsc_sync u_ack_sync (
		.i_clk(i_sclk),
		.i_resetn(i_resetn),
		.i_d(core_ff.ack),
		.o_q(ack_sync)
	);

	always_comb begin
		logic [2:0] w;
		logic [7:0] obyte;
		logic load;
		w = bus_width(lnk_ff.opc, lnk_ff.cnt);
		obyte = ERASED_BYTE;
		load = 1'b0;
		nxt_lnk = lnk_ff;
		nxt_evt = evt_ff;
		case (w)
			3'h2: nxt_lnk.shin = {lnk_ff.shin[29:0], i_io[1:0]};
			3'h4: nxt_lnk.shin = {lnk_ff.shin[27:0], i_io};
			default: nxt_lnk.shin = {lnk_ff.shin[30:0], i_io[0]};
		endcase
		if (lnk_ff.cnt != CNT_MAX) begin
			nxt_lnk.cnt = lnk_ff.cnt + 7'h01;
		end
		if (nxt_lnk.cnt == CNT_OPC_END) begin
			nxt_lnk.opc = nxt_lnk.shin[7:0];
		end
		if (nxt_lnk.cnt == CNT_ADDR_END) begin
			case (lnk_ff.opc)
				OPC_SFDP_RD, OPC_SEC_RD, OPC_SEC_ERASE, OPC_SEC_PROG: begin
					nxt_lnk.addr = nxt_lnk.shin[23:0];
					nxt_lnk.koff = nxt_lnk.shin[7:0];
				end
				default: ;
			endcase
			if (lnk_ff.opc == OPC_SEC_ERASE) begin
				nxt_evt = '{~evt_ff.tgl, EV_ARM, nxt_lnk.shin[23:0], 8'h00};
			end else if (lnk_ff.opc == OPC_SEC_RD) begin
				nxt_evt = '{~evt_ff.tgl, EV_READ, nxt_lnk.shin[23:0], 8'h00};
			end
		end
		// Any edge past the last address bit cancels a pending erase
		if (lnk_ff.opc == OPC_SEC_ERASE && nxt_lnk.cnt == CNT_ADDR_END + 7'h01) begin
			nxt_evt = '{~evt_ff.tgl, EV_DISARM, lnk_ff.addr, 8'h00};
		end
		// Program bytes are forwarded one by one as they complete
		if (lnk_ff.opc == OPC_SEC_PROG && lnk_ff.cnt >= CNT_ADDR_END) begin
			nxt_lnk.bidx = lnk_ff.bidx + 3'h1;
			if (lnk_ff.bidx == 3'h7) begin
				nxt_evt = '{~evt_ff.tgl, EV_PROG, {lnk_ff.addr[23:8], lnk_ff.koff},
					nxt_lnk.shin[7:0]};
				nxt_lnk.koff = lnk_ff.koff + 8'h01;
			end
		end
		if (nxt_lnk.cnt == data_start(lnk_ff.opc) && !lnk_ff.dphase) begin
			nxt_lnk.dphase = 1'b1;
			load = 1'b1;
		end else if (lnk_ff.dphase) begin
			load = (w == 3'h4) ? (lnk_ff.bidx == 3'h1) :
				(w == 3'h2) ? (lnk_ff.bidx == 3'h3) : (lnk_ff.bidx == 3'h7);
		end
		case (lnk_ff.opc)
			OPC_SFDP_RD: obyte = sfdp_byte(lnk_ff.koff);
			// Word is taken only once the core has answered the prefetch
			OPC_SEC_RD: obyte = (ack_sync == evt_ff.tgl) ? core_ff.rdata : ERASED_BYTE;
			OPC_UID_RD: obyte = UNIQUE_ID[{3'h7 - lnk_ff.koff[2:0], 3'h0} +: 8];
			OPC_ID_DUAL, OPC_ID_QUAD: obyte = lnk_ff.koff[0] ? DEVICE_ID : MAKER_ID;
			default: obyte = ERASED_BYTE;
		endcase
		if (load) begin
			nxt_lnk.oshr = obyte;
			nxt_lnk.bidx = 3'h0;
			nxt_lnk.koff = lnk_ff.koff + 8'h01;
			if (lnk_ff.opc == OPC_SEC_RD) begin
				nxt_evt = '{~evt_ff.tgl, EV_READ, {lnk_ff.addr[23:8], lnk_ff.koff + 8'h01},
					8'h00};
			end
		end else if (lnk_ff.dphase) begin
			nxt_lnk.oshr = lnk_ff.oshr << w;
			nxt_lnk.bidx = lnk_ff.bidx + 3'h1;
		end
	end

	always_ff @(posedge i_sclk or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			lnk_ff <= '0;
		end else begin
			lnk_ff <= nxt_lnk;
		end
	end

	// Event slot survives select so its toggle stays coherent with the core
	always_ff @(posedge i_sclk or negedge i_resetn) begin
		if (!i_resetn) begin
			evt_ff <= '0;
		end else begin
			evt_ff <= nxt_evt;
		end
	end

	// ==========================================================
	// Link domain, falling edges drive the lines
	always_comb begin
		nxt_drv = '0;
		if (lnk_ff.dphase) begin
			case (bus_width(lnk_ff.opc, lnk_ff.cnt))
				3'h4: nxt_drv = '{lnk_ff.oshr[7:4], 4'hF};
				3'h2: nxt_drv = '{{2'h0, lnk_ff.oshr[7:6]}, 4'h3};
				default: nxt_drv = '{{2'h0, lnk_ff.oshr[7], 1'b0}, 4'h2};
			endcase
		end
	end

	always_ff @(negedge i_sclk or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			drv_ff <= '0;
		end else begin
			drv_ff <= nxt_drv;
		end
	end

	assign o_io = drv_ff.io;
	assign o_io_oe = drv_ff.oe;

	// ==========================================================
	// Core domain
	fsc_sync u_req_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_d(evt_ff.tgl),
		.o_q(req_sync)
	);

	fsc_sync #(.RST_VAL(1'b1)) u_cs_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_d(i_cs_n),
		.o_q(cs_sync)
	);

	fsc_secmem u_mem (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_we(mem_we),
		.i_erase(mem_erase),
		.i_waddr(mem_waddr),
		.i_wdata(evt_ff.data),
		.i_raddr(core_ff.raddr),
		.o_rdata(mem_rdata)
	);

	always_comb begin
		logic [1:0] ev_area;
		logic ev_ok;
		ev_area = fsc_area_idx(evt_ff.addr);
		ev_ok = (ev_area != AREA_NONE) && core_ff.write_latch_flag && core_ff.state == CORE_IDLE;
		if (ev_area == 2'h0) begin
			ev_ok = ev_ok && !core_ff.lock[0];
		end else if (ev_area == 2'h1) begin
			ev_ok = ev_ok && !core_ff.lock[1];
		end else begin
			ev_ok = ev_ok && !core_ff.lock[2];
		end
		nxt_core = core_ff;
		mem_we = 1'b0;
		mem_erase = 1'b0;
		mem_waddr = {ev_area, evt_ff.addr[7:0]};
		nxt_core.req_seen = req_sync;
		nxt_core.cs_q = cs_sync;
		nxt_core.rd_pend = {core_ff.rd_pend[0], 1'b0};
		nxt_core.reg_rdata = 32'h0000_0000;
		if (req_sync != core_ff.req_seen) begin
			nxt_core.ack = (evt_ff.kind == EV_READ) ? core_ff.ack : req_sync; // Reads answer later
			case (evt_ff.kind)
				EV_READ: begin
					nxt_core.rd_bad = (ev_area == AREA_NONE);
					nxt_core.raddr = {(ev_area == AREA_NONE) ? 2'h0 : ev_area, evt_ff.addr[7:0]};
					nxt_core.rd_pend = 2'b01;
				end
				EV_PROG: begin
					mem_we = ev_ok;
					nxt_core.prog_seen = core_ff.prog_seen | ev_ok;
				end
				EV_ARM: begin
					nxt_core.armed = ev_ok;
					nxt_core.area = ev_area;
				end
				default: nxt_core.armed = 1'b0;
			endcase
		end
		if (core_ff.rd_pend[1]) begin
			nxt_core.rdata = core_ff.rd_bad ? ERASED_BYTE : mem_rdata;
			nxt_core.ack = ~core_ff.ack;
		end
		if (cs_sync && !core_ff.cs_q) begin
			if (core_ff.armed) begin
				nxt_core.state = CORE_ERASE;
				nxt_core.ecnt = ECW'(ERASE_CYCLES - 1);
			end
			if (core_ff.prog_seen) begin
				nxt_core.write_latch_flag = 1'b0;
			end
			nxt_core.armed = 1'b0;
			nxt_core.prog_seen = 1'b0;
		end
		case (core_ff.state)
			CORE_ERASE: begin
				// Cells are cleared in the final 256 cycles of the erase time
				if (core_ff.ecnt < ECW'(AREA_BYTES)) begin
					mem_we = 1'b1;
					mem_erase = 1'b1;
					mem_waddr = {core_ff.area, core_ff.ecnt[7:0]};
				end
				nxt_core.ecnt = core_ff.ecnt - ECW'(1);
				if (core_ff.ecnt == '0) begin
					nxt_core.state = CORE_IDLE;
					nxt_core.write_latch_flag = 1'b0;
				end
			end
			CORE_IDLE: ;
			default: nxt_core.state = CORE_IDLE;
		endcase
		if (i_reg_wr && i_reg_addr == REG_CTRL) begin
			nxt_core.lock = core_ff.lock | i_reg_wdata[LOCK_LSB +: 3];
			if (i_reg_wdata[CTRL_WEL_SET_BIT]) begin
				nxt_core.write_latch_flag = 1'b1;
			end else if (i_reg_wdata[CTRL_WEL_CLR_BIT]) begin
				nxt_core.write_latch_flag = 1'b0;
			end
		end
		if (i_reg_rd && i_reg_addr == REG_CTRL) begin
			nxt_core.reg_rdata[LOCK_LSB +: 3] = core_ff.lock;
		end else if (i_reg_rd && i_reg_addr == REG_STATUS) begin
			nxt_core.reg_rdata[STAT_BUSY_BIT] = (core_ff.state == CORE_ERASE);
			nxt_core.reg_rdata[STAT_WEL_BIT] = core_ff.write_latch_flag;
			nxt_core.reg_rdata[LOCK_LSB +: 3] = core_ff.lock;
			nxt_core.reg_rdata[STAT_ARM_BIT] = core_ff.armed;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			core_ff <= '{CORE_IDLE, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0, '0, WEL_RST, LOCK_RST,
				10'h000, 1'b0, 2'h0, 1'b0, 8'h00, 32'h0000_0000};
		end else begin
			core_ff <= nxt_core;
		end
	end

	assign o_reg_rdata = core_ff.reg_rdata;

	// ==========================================================
	// Checks
	sequence erase_launch;
		$rose(core_ff.state == CORE_ERASE);
	endsequence

	chk_erase_needs_wel: assert property (@(posedge i_clk) disable iff (!i_resetn)
		erase_launch |-> $past(core_ff.write_latch_flag) && $past(cs_sync, 1) && !$past(core_ff.cs_q))
		else $error("Erase launched without write latch");
	chk_busy_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
		erase_launch |-> (core_ff.state == CORE_ERASE)[*8])
		else $error("Busy dropped early");
	chk_wel_end_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(core_ff.state == CORE_ERASE && core_ff.ecnt == '0 && !i_reg_wr)
		|=> !core_ff.write_latch_flag && core_ff.state == CORE_IDLE)
		else $error("Write latch not cleared at erase end");
	chk_lock_guard: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(mem_we && !mem_erase) |-> core_ff.write_latch_flag && !core_ff.lock[mem_waddr[9:8]])
		else $error("Write reached locked area");
	chk_release_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(cs_sync && core_ff.cs_q) |-> o_io_oe == 4'h0)
		else $error("Lines driven while deselected");
	chk_sfdp_start: assert property (@(posedge i_sclk) disable iff (!lnk_rst_n)
		($rose(lnk_ff.dphase) && lnk_ff.opc == OPC_SFDP_RD) |-> lnk_ff.cnt == CNT_DATA_START)
		else $error("Parameter data started at wrong clock");
	chk_uid_start: assert property (@(posedge i_sclk) disable iff (!lnk_rst_n)
		($rose(lnk_ff.dphase) && lnk_ff.opc == OPC_UID_RD) |-> lnk_ff.cnt == CNT_DATA_START)
		else $error("Unique number started at wrong clock");
	chk_read_lane: assert property (@(posedge i_sclk) disable iff (!lnk_rst_n)
		(lnk_ff.dphase && lnk_ff.opc == OPC_SEC_RD) |-> o_io_oe == 4'h2)
		else $error("Area read not on single output line");
	chk_offset_step: assert property (@(posedge i_sclk) disable iff (!lnk_rst_n)
		(lnk_ff.dphase && lnk_ff.opc == OPC_SEC_RD && lnk_ff.bidx == 3'h0 && lnk_ff.koff == 8'h00)
		|-> ##8 lnk_ff.koff == 8'h01)
		else $error("Offset did not wrap and advance");
	chk_dual_width: assert property (@(posedge i_sclk) disable iff (!lnk_rst_n)
		(lnk_ff.dphase && lnk_ff.opc == OPC_ID_DUAL) |-> o_io_oe == 4'h3)
		else $error("Dual read not on two lines");
	chk_quad_width: assert property (@(posedge i_sclk) disable iff (!lnk_rst_n)
		(lnk_ff.dphase && lnk_ff.opc == OPC_ID_QUAD) |-> o_io_oe == 4'hF)
		else $error("Quad read not on four lines");
endmodule
`default_nettype wire

// ===== sim/fsc_host.sv
// Host controller model: drives select, link clock and data lines
`timescale 1ns/100ps
`default_nettype none
module fsc_host (
	// Link pins towards the device
	output logic o_sclk,
	output logic o_cs_n,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe,
	// Resolved data lines
	input wire logic [3:0] i_io
);
	// ==========================================================
	// Link clock of 125 ns, still and low outside frames
	localparam real HP = 62.5;
	logic [127:0] rx;

	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
		o_io_oe = 4'h0;
		rx = '0;
	end

	// Data set after the fall, device samples on the rise
	task automatic tick(input logic [3:0] v, input int rl);
		o_io = v;
		#HP o_sclk = 1'b1;
		case (rl)
			1: rx = {rx[126:0], i_io[1]};
			2: rx = {rx[125:0], i_io[1:0]};
			4: rx = {rx[123:0], i_io};
			default: ;
		endcase
		#HP o_sclk = 1'b0;
	endtask

	// ==========================================================
	// One frame: opcode, header clocks on hl lanes, nrd read clocks
	task automatic cmd(input logic [7:0] op, input logic [63:0] hdr, input int hclk,
		input int hl, input int nrd, input int rl);
		int i;
		logic [3:0] lane_oe;
		lane_oe = (hl == 4) ? 4'hF : (hl == 2) ? 4'h3 : 4'h1;
		rx = '0;
		o_cs_n = 1'b0;
		o_io_oe = 4'h1;
		#HP;
		for (i = 7; i >= 0; i--) begin
			tick({3'h0, op[i]}, 0);
		end
		o_io_oe = lane_oe;
		for (i = 0; i < hclk; i++) begin
			tick(4'(hdr[63:60] >> (4 - hl)), 0);
			hdr = hdr << hl;
		end
		o_io_oe = 4'h0;
		for (i = 0; i < nrd; i++) begin
			tick(o_io, rl);
		end
		// Select stays low through every byte of the frame
		#HP o_cs_n = 1'b1;
		#500;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the security-area command block
`timescale 1ns/100ps
`default_nettype none
module tb import fsc_pkg::*; ();
	// ==========================================================
	// Identification values, arbitrary
	localparam logic [7:0] MAKER = 8'h5C;
	localparam logic [7:0] DEVID = 8'h71;
	localparam logic [63:0] UID = 64'h1357_9BDF_2468_ACE0;
	localparam logic [7:0] CODES [3] = '{AREA1_CODE, AREA2_CODE, AREA3_CODE};

	logic i_clk, i_resetn, reg_wr, reg_rd, sclk, cs_n, wel_m;
	logic [3:0] reg_addr, h_io, h_oe, d_io, d_oe, io_w;
	logic [31:0] reg_wdata, reg_rdata, st;
	logic [7:0] mem [3][256];
	logic [7:0] rnd;
	logic [23:0] pd;
	logic [2:0] lk;
	int n_errors, comparisons, a, k;

	// No pull on the lines: an undriven line shows the inverse of the host value
	assign io_w = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & ~h_io);

	fsc_top #(.ERASE_CYCLES(300), .MAKER_ID(MAKER), .DEVICE_ID(DEVID), .UNIQUE_ID(UID)) uut (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_io(io_w), .o_io(d_io), .o_io_oe(d_oe));
	fsc_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io), .o_io_oe(h_oe), .i_io(io_w));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [31:0] st_exp();
		return {27'h0, lk, wel_m, 1'b0};
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [3:0] ad, input logic [31:0] d);
		@(posedge i_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge i_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] ad, output logic [31:0] d);
		@(posedge i_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge i_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic status_is();
		reg_read(REG_STATUS, st);
		check(st, st_exp());
	endtask

	task automatic set_wel();
		reg_write(REG_CTRL, 32'h0000_0001);
		wel_m = 1'b1;
	endtask

	// Bounded poll: busy must show, then drop
	task automatic erase_wait();
		int n;
		bit seen_busy;
		seen_busy = 0;
		for (n = 0; n < 500; n++) begin
			reg_read(REG_STATUS, st);
			if (st[STAT_BUSY_BIT] === 1'b1) seen_busy = 1;
			else if (seen_busy) break;
		end
		if (n == 500) begin
			n_errors++;
			complete_run();
		end
		check(seen_busy, 1);
	endtask

	task automatic rd_area(input int ai, input logic [7:0] off, input int n);
		int j;
		host.cmd(OPC_SEC_RD, {8'h00, CODES[ai], off, 40'h0}, 32, 1, 8 * n, 1);
		for (j = 0; j < n; j++) begin
			check(host.rx[8 * (n - 1 - j) +: 8], mem[ai][(off + j) % 256]);
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		i_resetn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rnd = 8'h08;
		lk = 3'h0;
		wel_m = 1'b0;
		pd = 24'h0;
		n_errors = 0;
		comparisons = 0;
		repeat (12) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clk);
		check(d_oe, 4'h0);
		status_is();
		reg_read(4'h8, st);
		check(st, 32'h0);
		for (a = 0; a < AREA_COUNT; a++) begin
			set_wel();
			status_is();
			host.cmd(OPC_SEC_ERASE, {8'h00, CODES[a], 48'h0}, 24, 1, 0, 1);
			erase_wait();
			for (k = 0; k < AREA_BYTES; k++) mem[a][k] = ERASED_BYTE;
			wel_m = 1'b0;
			status_is();
		end
		// One clock too many: erase dropped, latch kept
		set_wel();
		host.cmd(OPC_SEC_ERASE, {8'h00, AREA1_CODE, 48'h0}, 25, 1, 0, 1);
		status_is();
		for (k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			pd = {pd[15:0], rnd};
			mem[1][(254 + k) % 256] &= rnd;
		end
		host.cmd(OPC_SEC_PROG, {8'h00, AREA2_CODE, 8'hFE, pd, 16'h0}, 48, 1, 0, 1);
		wel_m = 1'b0;
		status_is();
		rd_area(1, 8'hFE, 4);
		host.cmd(OPC_SEC_ERASE, {8'h00, AREA2_CODE, 48'h0}, 24, 1, 0, 1);
		status_is();
		rd_area(1, 8'hFE, 4);
		reg_write(REG_CTRL, 32'h0000_0010);
		lk = 3'b100;
		set_wel();
		host.cmd(OPC_SEC_PROG, {8'h00, AREA3_CODE, 16'h0, 32'h0}, 40, 1, 0, 1);
		host.cmd(OPC_SEC_ERASE, {8'h00, AREA3_CODE, 48'h0}, 24, 1, 0, 1);
		status_is();
		reg_write(REG_CTRL, 32'h0000_0002);
		wel_m = 1'b0;
		rd_area(2, 8'h00, 2);
		host.cmd(OPC_SEC_RD, {8'h00, 8'h40, 8'h00, 40'h0}, 32, 1, 8, 1);
		check(host.rx[7:0], ERASED_BYTE);
		host.cmd(OPC_SFDP_RD, {16'h0, 8'hFE, 40'h0}, 32, 1, 32, 1);
		check(host.rx[31:0], 32'hFFFF_5346);
		host.cmd(OPC_ID_DUAL, {24'h0, 8'hF0, 32'h0}, 16, 2, 16, 2);
		check(host.rx[31:0], {MAKER, DEVID, MAKER, DEVID});
		host.cmd(OPC_ID_QUAD, {24'h0, 8'hF0, 32'h0}, 12, 4, 8, 4);
		check(host.rx[31:0], {MAKER, DEVID, MAKER, DEVID});
		host.cmd(OPC_UID_RD, 64'h0, 32, 1, 72, 1);
		check(host.rx[71:8], UID);
		check(host.rx[7:0], UID[63:56]);
		check(d_oe, 4'h0);
		complete_run();
	end
endmodule
`default_nettype wire
